// file: kmd_keypad_monitor.v
// keypad monitor display control with apb register slave
//
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/100ps
`include "kmd_regs.vh"
module kmd_keypad_monitor #(
   parameter DEBOUNCE_CYC = `KMD_DEBOUNCE_MS * `KMD_MS_CYCLES,
   parameter HOLD_CYC = `KMD_HOLD_MS * `KMD_MS_CYCLES,
   parameter REPEAT_CYC = `KMD_REPEAT_MS * `KMD_MS_CYCLES,
   parameter BLINK_CYC = `KMD_BLINK_MS * `KMD_MS_CYCLES,
   parameter VAL_W = 16
) (
   input wire clock_in,
   input wire rst_b_in,
   input wire psel_in,
   input wire penable_in,
   input wire pwrite_in,
   input wire [11:0] paddr_in,
   input wire [31:0] pwdata_in,
   output reg [31:0] prdata_out,
   output reg pready_out,
   output reg pslverr_out,
   input wire key_up_in,
   input wire key_down_in,
   input wire function_data_key_in,
   input wire running_mode_in,
   input wire motor2_active_in,
   input wire freq_cmd1_active_in,
   input wire freq_cmd2_active_in,
   input wire [VAL_W-1:0] out_freq_in,
   input wire [VAL_W-1:0] out_freq_comp_in,
   input wire [VAL_W-1:0] out_current_in,
   input wire [VAL_W-1:0] out_voltage_in,
   input wire [VAL_W-1:0] torque_in,
   input wire [VAL_W-1:0] input_power_in,
   input wire [VAL_W-1:0] pid_command_in,
   input wire [VAL_W-1:0] pid_feedback_in,
   input wire [VAL_W-1:0] timer_remain_in,
   input wire [VAL_W-1:0] pid_output_in,
   input wire [VAL_W-1:0] load_factor_in,
   input wire [VAL_W-1:0] motor_output_in,
   input wire [VAL_W-1:0] nv_ref_in,
   output reg [15:0] digits_out,
   output reg [3:0] dp_out,
   output reg [1:0] letter_out,
   output reg dashes_out,
   output reg overflow_out,
   output reg [3:0] blink_digit_out,
   output reg led_hz_out,
   output reg led_a_out,
   output reg led_kw_out,
   output reg nv_save_out,
   output reg [VAL_W-1:0] nv_save_data_out
);
   // ---------------------------------------------------------------
   // constants
   // ---------------------------------------------------------------
   localparam [VAL_W-1:0] LIMIT = 16'd9999;
   localparam [4:0] MON_SPEED = 5'd0;
   localparam [4:0] MON_CUR = 5'd3;
   localparam [4:0] MON_VOLT = 5'd4;
   localparam [4:0] MON_TORQ = 5'd8;
   localparam [4:0] MON_PWR = 5'd9;
   localparam [4:0] MON_PIDC = 5'd10;
   localparam [4:0] MON_PIDF = 5'd12;
   localparam [4:0] MON_TIMER = 5'd13;
   localparam [4:0] MON_PIDO = 5'd14;
   localparam [4:0] MON_LOAD = 5'd15;
   localparam [4:0] MON_MOUT = 5'd16;
   localparam [1:0] LET_NONE = 2'd0;
   localparam [1:0] LET_VOLT = 2'd1;
   localparam [1:0] LET_PCT = 2'd2;
   localparam [1:0] ST_MONITOR = 2'd0;
   localparam [1:0] ST_SHOW = 2'd1;
   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   reg [31:0] cfg_r;
   reg [31:0] coef_r;
   reg [31:0] motor_r;
   reg [VAL_W-1:0] ref1_r;
   reg [VAL_W-1:0] ref2_r;
   reg [VAL_W-1:0] pidcmd_r;
   reg loaded_r;
   reg [1:0] state_r;
   reg [1:0] cursor_r;
   reg [31:0] blink_cnt_r;
   reg blink_r;
   wire [4:0] monitor_item_select = cfg_r[`KMD_CFG_MON_LSB +: 5];
   wire [2:0] speed_item_select = cfg_r[`KMD_CFG_SPD_LSB +: 3];
   wire [3:0] freq_cmd1_source = cfg_r[`KMD_CFG_F1SRC_LSB +: 4];
   wire [3:0] freq_cmd2_source = cfg_r[`KMD_CFG_F2SRC_LSB +: 4];
   wire [1:0] pid_mode_select = cfg_r[`KMD_CFG_PID_LSB +: 2];
   wire [3:0] pid_remote_cmd_source = cfg_r[`KMD_CFG_PIDSRC_LSB +: 4];
   wire timer_operation_enable = cfg_r[`KMD_CFG_TIMER_BIT];
   wire [7:0] motor1_pole_count = coef_r[7:0];
   wire [7:0] motor2_pole_count = coef_r[15:8];
   wire [7:0] speed_display_coefficient = coef_r[23:16];
   wire [7:0] feed_rate_coefficient = coef_r[31:24];
   wire [15:0] motor1_max_frequency = motor_r[15:0];
   wire [15:0] motor2_max_frequency = motor_r[31:16];
   // ---------------------------------------------------------------
   // key debounce
   // ---------------------------------------------------------------
   // debounce, press pulse
   reg [2:0] key_r;
   reg [2:0] key_cand_r;
   reg [31:0] deb_cnt_r;
   reg [2:0] key_prev_r;
   wire [2:0] raw = {function_data_key_in, key_down_in, key_up_in};
   wire [2:0] press = key_r & ~key_prev_r;
   always @(posedge clock_in) begin
      if (!rst_b_in) begin
         key_r <= 3'h0;
         key_cand_r <= 3'h0;
         deb_cnt_r <= 32'h0;
         key_prev_r <= 3'h0;
      end else begin
         key_prev_r <= key_r;
         if (raw != key_cand_r) begin
            key_cand_r <= raw;
            deb_cnt_r <= 32'h0;
         end else if (deb_cnt_r >= DEBOUNCE_CYC - 1) begin
            key_r <= key_cand_r;
         end else begin
            deb_cnt_r <= deb_cnt_r + 32'h1;
         end
      end
   end
   reg [31:0] ud_hold_r;
   reg [31:0] fd_hold_r;
   reg ud_held_r;
   reg fd_held_r;
   wire ud_repeat = ud_held_r && ud_hold_r >= REPEAT_CYC - 1;
   wire fd_step = fd_held_r ? (fd_hold_r >= REPEAT_CYC - 1) : (fd_hold_r >= HOLD_CYC - 1);
   always @(posedge clock_in) begin
      if (!rst_b_in) begin
         ud_hold_r <= 32'h0;
         fd_hold_r <= 32'h0;
         ud_held_r <= 1'b0;
         fd_held_r <= 1'b0;
      end else begin
         if (!(key_r[0] | key_r[1])) begin
            ud_hold_r <= 32'h0;
            ud_held_r <= 1'b0;
         end else if ((!ud_held_r && ud_hold_r >= HOLD_CYC - 1) || ud_repeat) begin
            ud_hold_r <= 32'h0;
            ud_held_r <= 1'b1;
         end else begin
            ud_hold_r <= ud_hold_r + 32'h1;
         end
         if (!key_r[2]) begin
            fd_hold_r <= 32'h0;
            fd_held_r <= 1'b0;
         end else if (fd_step) begin
            fd_hold_r <= 32'h0;
            fd_held_r <= 1'b1;
         end else begin
            fd_hold_r <= fd_hold_r + 32'h1;
         end
      end
   end
   // ---------------------------------------------------------------
   // edit target selection
   // ---------------------------------------------------------------
   wire pid_process = (pid_mode_select == 2'd1) || (pid_mode_select == 2'd2);
   wire pid_on = pid_mode_select != 2'd0;
   wire tgt_pid = pid_process && monitor_item_select != MON_SPEED;
   wire tgt_f1 = !tgt_pid && freq_cmd1_active_in && freq_cmd1_source == 4'h0;
   wire tgt_f2 = !tgt_pid && freq_cmd2_active_in && freq_cmd2_source == 4'h0;
   wire may_edit = running_mode_in && (tgt_f1 || tgt_f2 || (tgt_pid && pid_remote_cmd_source == 4'h0));
   wire [VAL_W-1:0] ref_cur = tgt_pid ? pidcmd_r : (freq_cmd2_active_in ? ref2_r : ref1_r);
   function [VAL_W-1:0] pow10;
      input [1:0] pos;
      begin
         case (pos)
            2'd0: pow10 = 16'd1;
            2'd1: pow10 = 16'd10;
            2'd2: pow10 = 16'd100;
            default: pow10 = 16'd1000;
         endcase
      end
   endfunction
   function [VAL_W-1:0] step;
      input [VAL_W-1:0] v;
      input up;
      input [1:0] pos;
      begin
         if (up)
            step = (v + pow10(pos) > LIMIT) ? LIMIT : v + pow10(pos);
         else
            step = (v < pow10(pos)) ? 16'd0 : v - pow10(pos);
      end
   endfunction
   // ---------------------------------------------------------------
   // key state machine and apb
   // ---------------------------------------------------------------
   wire ud_event = press[0] | press[1] | ud_repeat;
   wire up_dir = key_r[0];
   wire apb_acc = psel_in && penable_in;
   wire apb_wr = apb_acc && pwrite_in && pready_out;
   reg [VAL_W-1:0] new_val;
   always @* begin
      new_val = step(ref_cur, up_dir, cursor_r);
   end
   always @(posedge clock_in) begin
      if (!rst_b_in) begin
         state_r <= ST_MONITOR;
         cursor_r <= 2'd0;
         cfg_r <= `KMD_CFG_RESET;
         coef_r <= `KMD_LIMIT_RESET;
         motor_r <= `KMD_MOTOR_RESET;
         ref1_r <= 16'h0;
         ref2_r <= 16'h0;
         pidcmd_r <= 16'h0;
         loaded_r <= 1'b0;
         nv_save_out <= 1'b0;
         nv_save_data_out <= 16'h0;
      end else begin
         nv_save_out <= 1'b0;
         if (!loaded_r) begin
            ref1_r <= nv_ref_in;
            loaded_r <= 1'b1;
         end
         if (!running_mode_in) begin
            state_r <= ST_MONITOR;
            cursor_r <= 2'd0;
         end else begin
            case (state_r)
               ST_MONITOR: begin
                  if (press[0] | press[1]) begin
                     state_r <= ST_SHOW;
                     cursor_r <= 2'd0;
                  end
               end
               ST_SHOW: begin
                  // cursor to msd then lower
                  // short press leaves on release, a long hold only moves the cursor
                  if (fd_step && key_r[2])
                     cursor_r <= cursor_r - 2'd1;
                  else if (key_prev_r[2] && !key_r[2] && !fd_held_r)
                     state_r <= ST_MONITOR;
                  if (ud_event && may_edit) begin
                     if (tgt_pid)
                        pidcmd_r <= new_val;
                     else if (tgt_f2)
                        ref2_r <= new_val;
                     else
                        ref1_r <= new_val;
                     nv_save_out <= tgt_f1;
                     nv_save_data_out <= new_val;
                  end
               end
               default: state_r <= ST_MONITOR;
            endcase
         end
         if (apb_wr) begin
            case (paddr_in)
               `KMD_CFG_ADDR: cfg_r <= pwdata_in;
               `KMD_LIMIT_ADDR: coef_r <= pwdata_in;
               `KMD_MOTOR_ADDR: motor_r <= pwdata_in;
               default: ;
            endcase
         end
      end
   end
   always @(posedge clock_in) begin
      if (!rst_b_in) begin
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
         prdata_out <= 32'h0;
      end else begin
         pready_out <= psel_in && penable_in && !pready_out;
         pslverr_out <= 1'b0;
         prdata_out <= 32'h0;
         if (apb_acc && !pready_out) begin
            case (paddr_in)
               `KMD_CFG_ADDR: prdata_out <= cfg_r;
               `KMD_LIMIT_ADDR: prdata_out <= coef_r;
               `KMD_MOTOR_ADDR: prdata_out <= motor_r;
               `KMD_STAT_ADDR: prdata_out <= {26'h0, cursor_r, 2'b00, state_r};
               `KMD_REF1_ADDR: prdata_out <= {16'h0, ref1_r};
               `KMD_REF2_ADDR: prdata_out <= {16'h0, ref2_r};
               `KMD_PIDCMD_ADDR: prdata_out <= {16'h0, pidcmd_r};
               default: pslverr_out <= 1'b1;
            endcase
         end
      end
   end
   // ---------------------------------------------------------------
   // value selection and display
   // ---------------------------------------------------------------
   always @(posedge clock_in) begin
      if (!rst_b_in) begin
         blink_cnt_r <= 32'h0;
         blink_r <= 1'b0;
      end else if (blink_cnt_r >= BLINK_CYC - 1) begin
         blink_cnt_r <= 32'h0;
         blink_r <= !blink_r;
      end else begin
         blink_cnt_r <= blink_cnt_r + 32'h1;
      end
   end
   wire [15:0] poles = motor2_active_in ? {8'h0, motor2_pole_count} : {8'h0, motor1_pole_count};
   wire [15:0] fmax = motor2_active_in ? motor2_max_frequency : motor1_max_frequency;
   wire [31:0] mspd = ({16'h0, out_freq_in} * 32'd120) / ((poles == 16'h0) ? 32'd1 : {16'h0, poles});
   wire [31:0] shaft = {16'h0, out_freq_in} * {24'h0, speed_display_coefficient};
   wire [31:0] feed_den = {16'h0, out_freq_in} * {24'h0, feed_rate_coefficient};
   wire [31:0] feed = {24'h0, speed_display_coefficient} / ((feed_den == 32'h0) ? 32'd1 : feed_den);
   // pid output scaled to max frequency
   wire [31:0] pido = ({16'h0, pid_output_in} * 32'd1000) / ((fmax == 16'h0) ? 32'd1 : {16'h0, fmax});
   reg [31:0] val;
   reg [2:0] units;
   reg [1:0] letter;
   reg dash;
   reg dp_blink;
   reg dp_on;
   reg kw_blink;
   always @* begin
      val = 32'h0;
      units = 3'b000;
      letter = LET_NONE;
      dash = 1'b0;
      dp_blink = 1'b0;
      dp_on = 1'b0;
      kw_blink = 1'b0;
      case (monitor_item_select)
         MON_SPEED: begin
            case (speed_item_select)
               3'd0: begin val = {16'h0, out_freq_in}; units = 3'b100; end
               3'd1: begin val = {16'h0, out_freq_comp_in}; units = 3'b100; end
               3'd2: begin val = {16'h0, ref_cur}; units = 3'b100; end
               3'd3: begin val = mspd; units = 3'b110; end
               3'd4: begin val = shaft; units = 3'b110; end
               3'd5: begin val = shaft; units = 3'b011; end
               default: begin val = feed; units = 3'b000; end
            endcase
         end
         MON_CUR: begin val = {16'h0, out_current_in}; units = 3'b010; end
         MON_VOLT: begin val = {16'h0, out_voltage_in}; letter = LET_VOLT; end
         MON_TORQ: val = {16'h0, torque_in};
         MON_PWR: begin val = {16'h0, input_power_in}; units = 3'b001; end
         MON_PIDC: begin val = {16'h0, pid_command_in}; dash = !pid_on; dp_blink = 1'b1; end
         MON_PIDF: begin val = {16'h0, pid_feedback_in}; dash = !pid_on; dp_on = 1'b1; end
         MON_TIMER: begin val = {16'h0, timer_remain_in}; dash = !timer_operation_enable; end
         MON_PIDO: begin val = pido; dash = !pid_on; dp_blink = 1'b1; end
         MON_LOAD: begin val = {16'h0, load_factor_in}; letter = LET_PCT; end
         MON_MOUT: begin val = {16'h0, motor_output_in}; units = 3'b001; kw_blink = 1'b1; end
         default: val = 32'h0;
      endcase
      if (state_r == ST_SHOW) begin
         val = {16'h0, ref_cur};
         units = 3'b100;
         letter = LET_NONE;
         dash = 1'b0;
      end
   end
   function [15:0] to_bcd;
      input [13:0] v;
      reg [13:0] d3;
      reg [13:0] d2;
      reg [13:0] d1;
      reg [13:0] d0;
      begin
         d3 = (v / 14'd1000) % 14'd10;
         d2 = (v / 14'd100) % 14'd10;
         d1 = (v / 14'd10) % 14'd10;
         d0 = v % 14'd10;
         to_bcd = {d3[3:0], d2[3:0], d1[3:0], d0[3:0]};
      end
   endfunction
   always @(posedge clock_in) begin
      if (!rst_b_in) begin
         digits_out <= 16'h0;
         dp_out <= 4'h0;
         letter_out <= 2'd0;
         dashes_out <= 1'b0;
         overflow_out <= 1'b0;
         blink_digit_out <= 4'h0;
         led_hz_out <= 1'b0;
         led_a_out <= 1'b0;
         led_kw_out <= 1'b0;
      end else begin
         overflow_out <= !dash && val > {16'h0, LIMIT};
         digits_out <= (dash || val > {16'h0, LIMIT}) ? 16'h0 : to_bcd(val[13:0]);
         dashes_out <= dash;
         letter_out <= letter;
         dp_out <= {3'b000, dp_on | (dp_blink & blink_r)};
         blink_digit_out <= (state_r == ST_SHOW) ? (4'h1 << cursor_r) : 4'h0;
         led_hz_out <= units[2];
         led_a_out <= units[1];
         led_kw_out <= units[0] & (!kw_blink | blink_r);
      end
   end
endmodule

// file: kmd_regs.vh
// register map, field layout, reset values and timing counts of the keypad monitor block
`ifndef KMD_REGS_VH
`define KMD_REGS_VH
// ---------------------------------------------------------------
// register offsets (byte addresses)
// ---------------------------------------------------------------
`define KMD_CFG_ADDR 12'h000
`define KMD_LIMIT_ADDR 12'h004
`define KMD_MOTOR_ADDR 12'h008
`define KMD_STAT_ADDR 12'h00c
`define KMD_REF1_ADDR 12'h010
`define KMD_REF2_ADDR 12'h014
`define KMD_PIDCMD_ADDR 12'h018
// ---------------------------------------------------------------
// cfg field positions
// ---------------------------------------------------------------
`define KMD_CFG_MON_LSB 0
`define KMD_CFG_SPD_LSB 5
`define KMD_CFG_F1SRC_LSB 8
`define KMD_CFG_F2SRC_LSB 12
`define KMD_CFG_PID_LSB 16
`define KMD_CFG_PIDSRC_LSB 18
`define KMD_CFG_TIMER_BIT 22
`define KMD_CFG_RESET 32'h0000_0000
`define KMD_LIMIT_RESET 32'h0000_0004
`define KMD_MOTOR_RESET 32'h1770_1770
// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define KMD_CLK_HZ 10000000
`define KMD_DEBOUNCE_MS 10
`define KMD_HOLD_MS 1000
`define KMD_REPEAT_MS 200
`define KMD_BLINK_MS 250
`define KMD_MS_CYCLES (`KMD_CLK_HZ / 1000)
`endif

// file: kmd_keypad_monitor_assertions.sv
// port checker for the keypad monitor block
`timescale 1ns/100ps
module kmd_keypad_monitor_assertions (
   input wire clock_in,
   input wire rst_b_in,
   input wire psel_in,
   input wire penable_in,
   input wire pready_out,
   input wire pslverr_out,
   input wire running_mode_in,
   input wire freq_cmd1_active_in,
   input wire [15:0] digits_out,
   input wire [1:0] letter_out,
   input wire dashes_out,
   input wire overflow_out,
   input wire [3:0] blink_digit_out,
   input wire led_hz_out,
   input wire led_kw_out,
   input wire nv_save_out
);
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (!rst_b_in);
   a_apb_one_wait: assert property (psel_in && penable_in && !pready_out |=> pready_out)
      else $error("apb answer late");
   a_ready_one_cycle: assert property (pready_out |=> !pready_out)
      else $error("pready longer than one cycle");
   a_err_with_ready: assert property (pslverr_out |-> pready_out)
      else $error("pslverr without pready");
   a_reset_clears_outputs: assert property (disable iff (1'b0) !rst_b_in |=> !nv_save_out && !pready_out)
      else $error("outputs not cleared in reset");
   a_powerup_shows_freq: assert property ($rose(rst_b_in) |-> ##3 led_hz_out && !led_kw_out)
      else $error("power-up item not shown");
   a_overflow_blank_digits: assert property (overflow_out |-> digits_out == 16'h0000 && !dashes_out)
      else $error("overflow with digits");
   a_letter_legal: assert property (letter_out != 2'h3)
      else $error("illegal unit letter");
   a_units_combo: assert property (!(led_hz_out && led_kw_out))
      else $error("hz and kw lit together");
   a_save_single_pulse: assert property (nv_save_out |=> !nv_save_out)
      else $error("save pulse too long");
   a_save_needs_running: assert property (nv_save_out |-> running_mode_in && $past(running_mode_in))
      else $error("save outside running mode");
   a_save_needs_cmd1: assert property (nv_save_out |-> $past(freq_cmd1_active_in))
      else $error("save without command 1");
   a_cursor_one_digit: assert property ($onehot0(blink_digit_out))
      else $error("more than one cursor digit");
endmodule
bind kmd_keypad_monitor kmd_keypad_monitor_assertions u_chk (.clock_in, .rst_b_in, .psel_in, .penable_in,
   .pready_out, .pslverr_out, .running_mode_in, .freq_cmd1_active_in, .digits_out, .letter_out, .dashes_out,
   .overflow_out, .blink_digit_out, .led_hz_out, .led_kw_out, .nv_save_out);

// file: kmd_operator.sv
// operator model pressing the panel keys
`timescale 1ns/100ps
module kmd_operator (
   input wire clock_in,
   output logic key_up_out,
   output logic key_down_out,
   output logic function_data_key_out
);
   initial begin
      key_up_out = 1'b0;
      key_down_out = 1'b0;
      function_data_key_out = 1'b0;
   end
   task automatic set(input int k, input logic v);
      @(posedge clock_in);
      case (k)
         0: key_up_out <= v;
         1: key_down_out <= v;
         default: function_data_key_out <= v;
      endcase
   endtask
   // keys stay stable far longer than any bounce
   task automatic push(input int k, input int hold);
      set(k, 1'b1);
      repeat (hold) @(posedge clock_in);
      set(k, 1'b0);
      repeat (10) @(posedge clock_in);
   endtask
endmodule

// file: test_kmd_keypad_monitor.sv
// self-checking bench for the keypad monitor block
`timescale 1ns/100ps
`include "kmd_regs.vh"
module test_kmd_keypad_monitor;
   logic clock_in = 1'b0;
   logic rst_b_in = 1'b0;
   logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
   logic [11:0] paddr_in = 12'h000;
   logic [31:0] pwdata_in = 32'h0;
   logic running_mode_in = 1'b1, motor2_active_in = 1'b0;
   logic freq_cmd1_active_in = 1'b1, freq_cmd2_active_in = 1'b0;
   logic [15:0] m [13] = '{16'd500, 16'd501, 16'd1111, 16'd2222, 16'd3333, 16'd4444, 16'd7777,
      16'd8888, 16'd123, 16'd3000, 16'd5555, 16'd6666, 16'd1234};
   logic [7:0] t_cfg [12] = '{8'h00, 8'h20, 8'h40, 8'h60, 8'h80, 8'ha0, 8'hc0, 8'h03, 8'h04, 8'h08, 8'h09, 8'h0f};
   logic [15:0] t_dig [12] = '{16'h0500, 16'h0501, 16'h1234, 16'h0, 16'h0, 16'h0, 16'h0, 16'h1111, 16'h2222,
      16'h3333, 16'h4444, 16'h5555};
   logic [2:0] t_led [12] = '{3'h4, 3'h4, 3'h4, 3'h6, 3'h6, 3'h3, 3'h0, 3'h2, 3'h0, 3'h0, 3'h1, 3'h0};
   wire [31:0] prdata_out;
   wire pready_out, pslverr_out, key_up, key_dn, key_fn;
   wire [15:0] digits_out, nv_save_data_out;
   wire [3:0] dp_out, blink_digit_out;
   wire [1:0] letter_out;
   wire dashes_out, overflow_out, led_hz_out, led_a_out, led_kw_out, nv_save_out;
   int err_count = 0;
   int comparisons = 0;
   int saves = 0;
   logic [15:0] last_save = 16'h0;
   logic [31:0] rd;
   logic er;
   always #50 clock_in = ~clock_in;
   kmd_keypad_monitor #(.DEBOUNCE_CYC(2), .HOLD_CYC(20), .REPEAT_CYC(5), .BLINK_CYC(4)) dut (
      .clock_in, .rst_b_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
      .prdata_out, .pready_out, .pslverr_out, .key_up_in(key_up), .key_down_in(key_dn),
      .function_data_key_in(key_fn), .running_mode_in, .motor2_active_in, .freq_cmd1_active_in,
      .freq_cmd2_active_in, .out_freq_in(m[0]), .out_freq_comp_in(m[1]), .out_current_in(m[2]),
      .out_voltage_in(m[3]), .torque_in(m[4]), .input_power_in(m[5]), .pid_command_in(m[6]),
      .pid_feedback_in(m[7]), .timer_remain_in(m[8]), .pid_output_in(m[9]), .load_factor_in(m[10]),
      .motor_output_in(m[11]), .nv_ref_in(m[12]), .digits_out, .dp_out, .letter_out, .dashes_out,
      .overflow_out, .blink_digit_out, .led_hz_out, .led_a_out, .led_kw_out, .nv_save_out,
      .nv_save_data_out);
   kmd_operator u_op (.clock_in, .key_up_out(key_up), .key_down_out(key_dn), .function_data_key_out(key_fn));
   always @(negedge clock_in) begin
      if (nv_save_out === 1'b1) begin
         saves++;
         last_save = nv_save_data_out;
      end
   end
   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clock_in);
      psel_in <= 1'b1;
      penable_in <= 1'b0;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge clock_in);
      penable_in <= 1'b1;
      do @(posedge clock_in); while (pready_out !== 1'b1);
      rd = prdata_out;
      er = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
   endtask
   task automatic cfg(input logic [31:0] v);
      apb(1'b1, `KMD_CFG_ADDR, v);
      repeat (4) @(negedge clock_in);
   endtask
   task automatic chk_disp(input logic [15:0] dg, input logic [2:0] led, input logic [1:0] lt,
      input logic ds, input logic ov, input logic care);
      check("display", {9'h0, lt, ds, ov, led, care ? dg : 16'h0}, {9'h0, letter_out, dashes_out, overflow_out,
         led_hz_out, led_a_out, led_kw_out, care ? digits_out : 16'h0});
   endtask
   task automatic blink_chk(input string what, input logic sel, input logic steady);
      int n;
      n = 0;
      repeat (12) begin
         @(negedge clock_in);
         n += sel ? led_kw_out : dp_out[0];
      end
      check(what, 32'h1, {31'h0, steady ? n == 12 : (n > 0 && n < 12)});
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_regs;
      chk_disp(16'h0500, 3'h4, 2'h0, 1'b0, 1'b0, 1'b1);
      apb(1'b0, `KMD_CFG_ADDR, 32'h0);
      check("cfg", `KMD_CFG_RESET, rd);
      apb(1'b0, `KMD_LIMIT_ADDR, 32'h0);
      check("limit", `KMD_LIMIT_RESET, rd);
      apb(1'b0, `KMD_MOTOR_ADDR, 32'h0);
      check("motor", `KMD_MOTOR_RESET, rd);
      apb(1'b0, 12'h020, 32'h0);
      check("unmapped err", 32'h1, {31'h0, er});
      $display("test regs done");
   endtask
   task automatic t_monitor;
      for (int i = 0; i < 12; i++) begin
         cfg({24'h0, t_cfg[i]});
         chk_disp(t_dig[i], t_led[i], {i == 11, i == 8}, 1'b0, i == 3, i < 4 || i > 6);
      end
      @(posedge clock_in);
      m[0] <= 16'd12000;
      cfg(32'h0);
      chk_disp(16'h0, 3'h4, 2'h0, 1'b0, 1'b1, 1'b1);
      @(posedge clock_in);
      m[0] <= 16'd500;
      $display("test monitor done");
   endtask
   task automatic t_pid;
      cfg(32'h0000_000a);
      chk_disp(16'h0, 3'h0, 2'h0, 1'b1, 1'b0, 1'b0);
      cfg(32'h0000_000d);
      chk_disp(16'h0, 3'h0, 2'h0, 1'b1, 1'b0, 1'b0);
      cfg(32'h0040_000d);
      chk_disp(16'h0123, 3'h0, 2'h0, 1'b0, 1'b0, 1'b1);
      cfg(32'h0001_000c);
      chk_disp(16'h8888, 3'h0, 2'h0, 1'b0, 1'b0, 1'b1);
      blink_chk("feedback point", 1'b0, 1'b1);
      cfg(32'h0001_000a);
      chk_disp(16'h7777, 3'h0, 2'h0, 1'b0, 1'b0, 1'b1);
      blink_chk("command point", 1'b0, 1'b0);
      cfg(32'h0001_000e);
      check("pid out", 32'h0500, {16'h0, digits_out});
      blink_chk("output point", 1'b0, 1'b0);
      apb(1'b1, `KMD_MOTOR_ADDR, 32'h0bb8_1770);
      @(posedge clock_in);
      motor2_active_in <= 1'b1;
      repeat (4) @(negedge clock_in);
      check("pid out motor2", 32'h1000, {16'h0, digits_out});
      cfg(32'h0000_0010);
      check("motor output", 32'h6666, {16'h0, digits_out});
      blink_chk("kw led", 1'b1, 1'b0);
      cfg(32'h0);
      $display("test pid done");
   endtask
   task automatic t_keys;
      u_op.push(0, 6);
      for (int i = 0; i < 100 && blink_digit_out !== 4'h1; i++) @(negedge clock_in);
      check("cursor", 32'h1, {28'h0, blink_digit_out});
      check("shown ref", 32'h1234, {16'h0, digits_out});
      u_op.push(0, 6);
      check("saves", 32'h1, saves);
      check("save data", 32'd1235, {16'h0, last_save});
      apb(1'b0, `KMD_REF1_ADDR, 32'h0);
      check("ref1", 32'd1235, rd);
      u_op.set(2, 1'b1);
      repeat (26) @(negedge clock_in);
      check("cursor msd", 32'h8, {28'h0, blink_digit_out});
      repeat (5) @(negedge clock_in);
      check("cursor next", 32'h4, {28'h0, blink_digit_out});
      u_op.set(2, 1'b0);
      repeat (10) @(posedge clock_in);
      u_op.push(2, 6);
      $display("test keys done");
   endtask
   task automatic t_lock;
      logic [31:0] r2;
      @(posedge clock_in);
      freq_cmd1_active_in <= 1'b0;
      freq_cmd2_active_in <= 1'b1;
      apb(1'b0, `KMD_REF2_ADDR, 32'h0);
      r2 = rd;
      repeat (3) u_op.push(0, 6);
      apb(1'b0, `KMD_REF2_ADDR, 32'h0);
      check("ref2 edited", 32'h1, {31'h0, rd !== r2});
      r2 = rd;
      cfg(32'h0000_1000);
      repeat (3) u_op.push(1, 6);
      apb(1'b0, `KMD_REF2_ADDR, 32'h0);
      check("ref2 kept", r2, rd);
      @(posedge clock_in);
      freq_cmd1_active_in <= 1'b1;
      freq_cmd2_active_in <= 1'b0;
      running_mode_in <= 1'b0;
      repeat (3) u_op.push(0, 6);
      apb(1'b0, `KMD_REF1_ADDR, 32'h0);
      check("ref1 kept", 32'd1235, rd);
      check("no new save", 32'h1, saves);
      @(posedge clock_in);
      running_mode_in <= 1'b1;
      $display("test lock done");
   endtask
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge clock_in);
      rst_b_in <= 1'b1;
      repeat (4) @(negedge clock_in);
      t_regs();
      t_monitor();
      t_pid();
      t_keys();
      t_lock();
      end_sim();
   end
   initial begin
      repeat (20000) @(posedge clock_in);
      err_count++;
      end_sim();
   end
endmodule
